// ### rtl/spc_pkg.sv
package spc_pkg;
  // Register byte offsets
  localparam logic [7:0] SPC_OFF_CMD = 8'h00;
  localparam logic [7:0] SPC_OFF_CFG = 8'h04;
  localparam logic [7:0] SPC_OFF_IEN = 8'h08;
  localparam logic [7:0] SPC_OFF_IDIS = 8'h0C;
  localparam logic [7:0] SPC_OFF_IMASK = 8'h10;
  localparam logic [7:0] SPC_OFF_STAT = 8'h14;
  // Command register bit positions
  localparam int SPC_CMD_TO_START = 11;
  localparam int SPC_CMD_SEND_ADDR = 12;
  localparam int SPC_CMD_ITER_CLR = 13;
  localparam int SPC_CMD_NONACK_FLAG_CLR = 14;
  localparam int SPC_CMD_TO_REARM = 15;
  localparam int SPC_CMD_DTR_ASSERT = 16;
  localparam int SPC_CMD_DTR_RELEASE = 17;
  localparam int SPC_CMD_RTS_ASSERT = 18;
  localparam int SPC_CMD_RTS_RELEASE = 19;
  // Configuration register field positions
  localparam int SPC_CFG_MODE_LSB = 0;
  localparam int SPC_CFG_CLKS_LSB = 4;
  localparam int SPC_CFG_CHAR_LENGTH_FIELD_LSB = 6;
  localparam int SPC_CFG_SYNC = 8;
  localparam int SPC_CFG_PAR_LSB = 9;
  localparam int SPC_CFG_STOP_LSB = 12;
  localparam int SPC_CFG_CHANNEL_TEST_MODE_LSB = 14;
  localparam int SPC_CFG_BIT_ORDER_SELECT = 16;
  localparam int SPC_CFG_NINE = 17;
  localparam int SPC_CFG_CLOCK_OUTPUT_ENABLE = 18;
  localparam int SPC_CFG_OVER = 19;
  localparam int SPC_CFG_NONACK_FLAG_INHIBIT = 20;
  localparam int SPC_CFG_SUCCESSIVE_NONACK_FLAG_DISABLE = 21;
  localparam int SPC_CFG_MAXIT_LSB = 24;
  localparam int SPC_CFG_FILTER = 28;
  // Writable bits of the configuration register
  localparam logic [31:0] SPC_CFG_WMASK = 32'h173F_FFFF;
  // Interrupt source positions owned by this block
  localparam int SPC_IRQ_ITER = 10;
  localparam int SPC_IRQ_NONACK_FLAG = 13;
  localparam int SPC_IRQ_MODEM_LSB = 16;
  // Implemented interrupt sources
  localparam logic [31:0] SPC_IRQ_VALID = 32'h000F_3FFF;
  // Reset values
  localparam logic [31:0] SPC_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SPC_IMASK_RST = 32'h0000_0000;
  // Mode, clock and parity codes that the logic decodes
  localparam logic [3:0] SPC_MODE_ISO_T0 = 4'h4;
  localparam logic [3:0] SPC_MODE_ISO_T1 = 4'h6;
  localparam logic [1:0] SPC_CLK_EXT = 2'h3;
  localparam logic [1:0] SPC_PAR_MULTIDROP = 2'h3;
  // Channel wiring modes
  typedef enum logic [1:0] {
    SPC_CH_NORMAL, SPC_CH_ECHO, SPC_CH_LOCAL, SPC_CH_REMOTE
  } spc_channel_test_mode_e;
endpackage

// ### rtl/spc_serial_port_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Time-out start waits for a received character
// - Send-address marks next character in multi-drop
// - Iteration clear works only in smart-card modes
// - NONACK_FLAG clear command clears non-acknowledge flag
// - Time-out rearm command restarts receive time-out
// - Terminal-ready commands drive pin low or high
// - Request-to-send commands drive pin low or high
// - Four-bit field selects operating mode
// - Clock select; serial clock driven when allowed
// - Length field 5 to 8, nine-bit overrides
// - Sync bit selects asynchronous or synchronous
// - Parity field: even, odd, forced, none, multi-drop
// - Stop bits: one, one-and-half async, two
// - Channel mode: normal, echo, local, remote loop
// - Bit order: LSB or MSB first
// - Oversampling sixteen or eight per bit
// - NONACK_FLAG inhibit suppresses non-acknowledge
// - Without successive disable, NONACK_FLAG every parity error
// - With disable, count errors, stop, raise iteration
// - Maximum iteration field sets error limit
// - Infrared filter: two-of-three majority vote
// - Interrupt enable writes set mask bits
// - Modem change sources sit at bits 16-19
// - Interrupt disable writes clear mask bits
// - Mask register reads back enabled sources
module spc_serial_port_ctrl
  import spc_pkg::*;
#(
  parameter int ITER_W = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the transmitter and receiver
  input wire logic tx_char_load,
  input wire logic tx_serial,
  input wire logic rx_parity_err,
  input wire logic rx_char_ok,
  input wire logic nonack_flag_seen,
  input wire logic sample_tick,
  input wire logic [31:0] ext_status,
  // Serial and modem pins
  input wire logic rxd_pin,
  input wire logic [3:0] modem_pins,
  output logic txd_pin,
  output logic dtr_n,
  output logic rts_n,
  output logic sck_oe_n,
  output logic irq,
  // Toward the receiver and transmitter
  output logic rx_line,
  output logic tx_addr_bit,
  output logic timeout_start,
  output logic timeout_rearm,
  output logic nonack_flag_req,
  // Decoded configuration
  output logic [3:0] op_mode,
  output logic [1:0] clk_src,
  output logic [3:0] char_bits,
  output logic sync_mode,
  output logic [2:0] parity_type,
  output logic [1:0] stop_bits,
  output logic msb_first,
  output logic over8
);

  // Whole module state in one record
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] cfg;
    logic [31:0] imask;
    logic iter_flag;
    logic nonack_flag_flag;
    logic [3:0] modem_chg;
    logic [3:0] modem_s1;
    logic [3:0] modem_s2;
    logic [3:0] modem_last;
    logic modem_primed;
    logic rxd_s1;
    logic rxd_s2;
    logic [2:0] filt_hist;
    logic rxd_f;
    logic txd;
    logic rx_line;
    logic dtr_n;
    logic rts_n;
    logic to_start;
    logic to_rearm;
    logic addr_pend;
    logic tx_addr_bit;
    logic nonack_flag_req;
    logic [ITER_W-1:0] iter_cnt;
    logic irq;
    logic sck_oe_n;
    logic [3:0] char_bits;
  } spc_state_s;

  spc_state_s st_r; // Registered state
  spc_state_s st_nxt; // Next state

  // Two-of-three majority vote
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Smart-card protocol modes
  function automatic logic is_iso(input logic [3:0] m);
    is_iso = (m == SPC_MODE_ISO_T0) || (m == SPC_MODE_ISO_T1);
  endfunction

  // Data bits per character from the configuration word
  function automatic logic [3:0] bits_of(input logic [31:0] c);
    if (c[SPC_CFG_NINE]) begin
      bits_of = 4'h9;
    end else begin
      bits_of = 4'h5 + {2'h0, c[SPC_CFG_CHAR_LENGTH_FIELD_LSB +: 2]};
    end
  endfunction

  // Status word as software sees it
  function automatic logic [31:0] stat_of(input spc_state_s s,
                                          input logic [31:0] ext);
    logic [31:0] w;
    w = ext & SPC_IRQ_VALID;
    w[SPC_IRQ_ITER] = s.iter_flag;
    w[SPC_IRQ_NONACK_FLAG] = s.nonack_flag_flag;
    w[SPC_IRQ_MODEM_LSB +: 4] = s.modem_chg;
    stat_of = w;
  endfunction

  // Next-state logic
  always_comb begin
    logic setup;
    logic wr_done;
    logic rd_done;
    logic [31:0] cmd;
    logic [3:0] mode;
    logic [ITER_W-1:0] max_it;
    logic [3:0] modem_ev;
    logic [31:0] stat;
    logic line_in;
    setup = 1'b0;
    wr_done = 1'b0;
    rd_done = 1'b0;
    cmd = 32'h0000_0000;
    mode = st_r.cfg[SPC_CFG_MODE_LSB +: 4];
    max_it = st_r.cfg[SPC_CFG_MAXIT_LSB +: ITER_W];
    modem_ev = 4'h0;
    stat = 32'h0000_0000;
    line_in = 1'b1;
    st_nxt = st_r;

    // Pulses last one cycle unless raised again below
    st_nxt.to_start = 1'b0;
    st_nxt.to_rearm = 1'b0;
    st_nxt.nonack_flag_req = 1'b0;

    // APB: answer in the access cycle that follows setup
    setup = psel && !penable;
    wr_done = psel && penable && st_r.pready && pwrite;
    rd_done = psel && penable && st_r.pready && !pwrite;
    st_nxt.pready = setup;
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        SPC_OFF_CFG: begin
          st_nxt.prdata = st_r.cfg;
        end
        SPC_OFF_IMASK: begin
          st_nxt.prdata = st_r.imask;
        end
        SPC_OFF_STAT: begin
          st_nxt.prdata = stat_of(st_r, ext_status);
        end
        SPC_OFF_CMD, SPC_OFF_IEN, SPC_OFF_IDIS: begin
          // Write-only registers read as zero
          st_nxt.prdata = 32'h0000_0000;
        end
        default: begin
          // Unmapped addresses answer with an error
          st_nxt.pslverr = 1'b1;
        end
      endcase
      // Writes to read-only registers are errors too
      if (pwrite && (paddr == SPC_OFF_IMASK || paddr == SPC_OFF_STAT)) begin
        st_nxt.pslverr = 1'b1;
      end
    end else begin
      st_nxt.prdata = st_r.prdata;
    end

    // Register writes take effect on the completing edge
    if (wr_done) begin
      case (paddr)
        SPC_OFF_CMD: begin
          cmd = pwdata;
        end
        SPC_OFF_CFG: begin
          // Reserved codes are stored as written; software keeps off them
          st_nxt.cfg = pwdata & SPC_CFG_WMASK;
        end
        SPC_OFF_IEN: begin
          st_nxt.imask = st_r.imask | (pwdata & SPC_IRQ_VALID);
        end
        SPC_OFF_IDIS: begin
          st_nxt.imask = st_r.imask & ~pwdata;
        end
        default: begin
          // Other offsets hold nothing writable here
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end

    // Time-out commands become one-cycle strobes
    st_nxt.to_start = cmd[SPC_CMD_TO_START];
    st_nxt.to_rearm = cmd[SPC_CMD_TO_REARM];

    // Modem outputs: disable wins if both are written together
    if (cmd[SPC_CMD_DTR_ASSERT]) begin
      st_nxt.dtr_n = 1'b0;
    end
    if (cmd[SPC_CMD_DTR_RELEASE]) begin
      st_nxt.dtr_n = 1'b1;
    end
    if (cmd[SPC_CMD_RTS_ASSERT]) begin
      st_nxt.rts_n = 1'b0;
    end
    if (cmd[SPC_CMD_RTS_RELEASE]) begin
      st_nxt.rts_n = 1'b1;
    end

    // Address bit: a pending mark is consumed by the next load
    if (tx_char_load) begin
      st_nxt.tx_addr_bit = st_r.addr_pend;
      st_nxt.addr_pend = 1'b0;
    end
    if (cmd[SPC_CMD_SEND_ADDR] &&
        st_r.cfg[SPC_CFG_PAR_LSB + 1 +: 2] == SPC_PAR_MULTIDROP) begin
      st_nxt.addr_pend = 1'b1;
    end

    // Flag clears first, so same-cycle events below win
    if (cmd[SPC_CMD_ITER_CLR] && is_iso(mode)) begin
      st_nxt.iter_flag = 1'b0;
      st_nxt.iter_cnt = '0;
    end
    if (cmd[SPC_CMD_NONACK_FLAG_CLR]) begin
      st_nxt.nonack_flag_flag = 1'b0;
    end
    if (nonack_flag_seen) begin
      st_nxt.nonack_flag_flag = 1'b1;
    end

    // A clean character ends a run of parity errors
    if (rx_char_ok) begin
      st_nxt.iter_cnt = '0;
    end

    // Smart-card parity error handling
    if (rx_parity_err && is_iso(mode)) begin
      if (!st_r.cfg[SPC_CFG_SUCCESSIVE_NONACK_FLAG_DISABLE]) begin
        st_nxt.nonack_flag_req = !st_r.cfg[SPC_CFG_NONACK_FLAG_INHIBIT];
      end else if (st_r.iter_cnt < max_it) begin
        // Counted error still answered with a NONACK_FLAG
        st_nxt.iter_cnt = st_r.iter_cnt + 1'b1;
        st_nxt.nonack_flag_req = !st_r.cfg[SPC_CFG_NONACK_FLAG_INHIBIT];
        if (st_r.iter_cnt + 1'b1 == max_it) begin
          st_nxt.iter_flag = 1'b1;
        end
      end else begin
        // Limit reached: stay silent and keep the flag raised
        st_nxt.iter_flag = 1'b1;
      end
    end

    // Modem inputs: two-stage sync, then change detect
    st_nxt.modem_s1 = modem_pins;
    st_nxt.modem_s2 = st_r.modem_s1;
    st_nxt.modem_last = st_r.modem_s2;
    st_nxt.modem_primed = 1'b1;
    // Priming avoids a false change on the first edge after reset
    if (st_r.modem_primed) begin
      modem_ev = st_r.modem_s2 ^ st_r.modem_last;
    end
    if (rd_done && paddr == SPC_OFF_STAT) begin
      st_nxt.modem_chg = 4'h0;
    end
    st_nxt.modem_chg = st_nxt.modem_chg | modem_ev;

    // Receive pin: sync, then optional majority filter
    st_nxt.rxd_s1 = rxd_pin;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    if (sample_tick) begin
      st_nxt.filt_hist = {st_r.filt_hist[1:0], st_r.rxd_s2};
    end
    if (st_r.cfg[SPC_CFG_FILTER]) begin
      st_nxt.rxd_f = maj3(st_r.filt_hist);
    end else begin
      st_nxt.rxd_f = st_r.rxd_s2;
    end
    line_in = st_r.rxd_f;

    // Channel wiring between pins, transmitter and receiver
    case (spc_channel_test_mode_e'(st_r.cfg[SPC_CFG_CHANNEL_TEST_MODE_LSB +: 2]))
      SPC_CH_NORMAL: begin
        st_nxt.txd = tx_serial;
        st_nxt.rx_line = line_in;
      end
      SPC_CH_ECHO: begin
        // Receiver still listens while the pin is echoed
        st_nxt.txd = line_in;
        st_nxt.rx_line = line_in;
      end
      SPC_CH_LOCAL: begin
        // Pin idles high while the loop is internal
        st_nxt.txd = 1'b1;
        st_nxt.rx_line = tx_serial;
      end
      SPC_CH_REMOTE: begin
        // Receiver sees idle; the pin pair is joined
        st_nxt.txd = line_in;
        st_nxt.rx_line = 1'b1;
      end
      default: begin
        st_nxt.txd = 1'b1;
        st_nxt.rx_line = 1'b1;
      end
    endcase

    // Serial clock pin is never driven on the external source
    st_nxt.sck_oe_n = !(st_nxt.cfg[SPC_CFG_CLOCK_OUTPUT_ENABLE] &&
      st_nxt.cfg[SPC_CFG_CLKS_LSB +: 2] != SPC_CLK_EXT);
    st_nxt.char_bits = bits_of(st_nxt.cfg);

    // Interrupt from any flagged and enabled source
    stat = stat_of(st_r, ext_status);
    st_nxt.irq = |(stat & st_r.imask);

    // Synchronous reset to a quiet, idle port
    if (rst) begin
      st_nxt = '0;
      st_nxt.cfg = SPC_CFG_RST;
      st_nxt.imask = SPC_IMASK_RST;
      st_nxt.rxd_s1 = 1'b1;
      st_nxt.rxd_s2 = 1'b1;
      // Modem lines idle high; matching that avoids false changes
      st_nxt.modem_s1 = 4'hF;
      st_nxt.modem_s2 = 4'hF;
      st_nxt.modem_last = 4'hF;
      st_nxt.filt_hist = 3'h7;
      st_nxt.rxd_f = 1'b1;
      st_nxt.txd = 1'b1;
      st_nxt.rx_line = 1'b1;
      st_nxt.dtr_n = 1'b1;
      st_nxt.rts_n = 1'b1;
      st_nxt.sck_oe_n = 1'b1;
      st_nxt.char_bits = bits_of(SPC_CFG_RST);
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign txd_pin = st_r.txd;
  assign dtr_n = st_r.dtr_n;
  assign rts_n = st_r.rts_n;
  assign sck_oe_n = st_r.sck_oe_n;
  assign irq = st_r.irq;
  assign rx_line = st_r.rx_line;
  assign tx_addr_bit = st_r.tx_addr_bit;
  assign timeout_start = st_r.to_start;
  assign timeout_rearm = st_r.to_rearm;
  assign nonack_flag_req = st_r.nonack_flag_req;
  assign op_mode = st_r.cfg[SPC_CFG_MODE_LSB +: 4];
  assign clk_src = st_r.cfg[SPC_CFG_CLKS_LSB +: 2];
  assign char_bits = st_r.char_bits;
  assign sync_mode = st_r.cfg[SPC_CFG_SYNC];
  assign parity_type = st_r.cfg[SPC_CFG_PAR_LSB +: 3];
  assign stop_bits = st_r.cfg[SPC_CFG_STOP_LSB +: 2];
  assign msb_first = st_r.cfg[SPC_CFG_BIT_ORDER_SELECT];
  assign over8 = st_r.cfg[SPC_CFG_OVER];

endmodule

// ### tb/spc_serial_port_ctrl_checker.sv
`timescale 1ns/1ps
module spc_chk
  import spc_pkg::*;
(
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and pins
  input wire logic tx_char_load,
  input wire logic rx_parity_err,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic sck_oe_n,
  input wire logic tx_addr_bit,
  input wire logic timeout_start,
  input wire logic timeout_rearm,
  input wire logic nonack_flag_req,
  input wire logic [1:0] clk_src,
  input wire logic [3:0] char_bits
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Command write completing at this edge
  logic cw;
  assign cw = psel && penable && pready && pwrite && paddr == SPC_OFF_CMD;
  a_dtr_low: assert property (cw && pwdata[16] && !pwdata[17] |=> !dtr_n)
    else $error("terminal ready not driven low");
  a_dtr_high: assert property (cw && pwdata[17] |=> dtr_n)
    else $error("terminal ready not driven high");
  a_rts_low: assert property (cw && pwdata[18] && !pwdata[19] |=> !rts_n)
    else $error("request to send not driven low");
  a_rts_high: assert property (cw && pwdata[19] |=> rts_n)
    else $error("request to send not driven high");
  a_tmo_start: assert property ($past(cw && pwdata[11]) == timeout_start)
    else $error("time-out start pulse wrong");
  a_tmo_rearm: assert property ($past(cw && pwdata[15]) == timeout_rearm)
    else $error("time-out rearm pulse wrong");
  a_nonack_flag_cause: assert property (nonack_flag_req |-> $past(rx_parity_err))
    else $error("nonack_flag without parity error");
  a_sck_drive: assert property (!sck_oe_n |-> clk_src != SPC_CLK_EXT)
    else $error("serial clock driven on external clock");
  a_len_range: assert property (char_bits >= 5 && char_bits <= 9)
    else $error("character length out of range");
  a_addr_hold: assert property (!tx_char_load |=> $stable(tx_addr_bit))
    else $error("address bit moved without load");
  a_mask_ro: assert property (psel && !penable && pwrite &&
    paddr == SPC_OFF_IMASK |=> pready && pslverr)
    else $error("mask write not refused");
endmodule
bind spc_serial_port_ctrl spc_chk i_chk (.*);

// ### tb/spc_line_partner.sv
`timescale 1ns/1ps
module spc_line_partner (
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic [3:0] flip,
  input wire logic rx_level,
  // Lines toward the port
  output logic rxd_pin,
  output logic [3:0] modem_pins
);
  // Remote modem idles its lines high; ring is line 0
  initial begin
    modem_pins = 4'hF;
    rxd_pin = 1'b1;
  end
  // Lines only move just after an edge, like a real far end
  always @(posedge sys_clk) begin
    modem_pins <= modem_pins ^ flip;
    rxd_pin <= rx_level;
  end
endmodule

// ### tb/tb_serial_port_control_and_mode.sv
`timescale 1ns/1ps
module tb_serial_port_control_and_mode;
  import spc_pkg::*;
  // Stimulus
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, ext_status = 0;
  logic tx_char_load = 0, tx_serial = 1, rx_parity_err = 0;
  logic rx_char_ok = 0, nonack_flag_seen = 0, sample_tick = 0, rx_level = 1;
  logic [3:0] flip = 0;
  // Design outputs and partner lines
  logic [31:0] prdata;
  logic pready, pslverr, txd_pin, dtr_n, rts_n, sck_oe_n, irq, rx_line;
  logic tx_addr_bit, timeout_start, timeout_rearm, nonack_flag_req, rxd_pin;
  logic sync_mode, msb_first, over8;
  logic [3:0] op_mode, char_bits, modem_pins;
  logic [1:0] clk_src, stop_bits;
  logic [2:0] parity_type;
  // Reference model state
  int errors = 0, comparisons = 0;
  logic [31:0] m_mask = 0, rd, v;
  logic er, md = 1, mr = 1;
  logic [15:0] lf = 16'd46232;
  logic [3:0] modes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};

  spc_serial_port_ctrl i_dut (.*);
  spc_line_partner i_line (.*);

  // 40 MHz clock
  initial forever #12.5 sys_clk = ~sys_clk;
  // Free-running filter strobe
  always @(posedge sys_clk) sample_tick <= ~sample_tick;

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Random words from a 16-bit shift register
  task rnd(output logic [31:0] r);
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    r[15:0] = lf;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    r[31:16] = lf;
  endtask

  // One APB transfer; waits for pready, bounded by a count
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A transfer that never completes is a failure
    if (n >= 50) errors++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Write, then let the effect reach the pins
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1, d);
    tick(1);
  endtask

  task pulse_err;
    rx_parity_err <= 1;
    tick(1);
    rx_parity_err <= 0;
    tick(1);
  endtask

  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    tick(20000);
    errors++;
    end_of_test;
  end

  initial begin
    tick(16);
    rst <= 0;
    apb(SPC_OFF_CFG, 0, 0);
    chk("cfg", rd, SPC_CFG_RST);
    apb(SPC_OFF_IMASK, 0, 0);
    chk("imask", rd, SPC_IMASK_RST);
    chk("pins", {dtr_n, rts_n, sck_oe_n, char_bits}, 7'h75);
    $display("test reset done");
    // Random legal configurations; reserved codes kept out
    for (int i = 0; i < 8; i++) begin
      rnd(v);
      v = v & SPC_CFG_WMASK;
      v[3:0] = modes[i % 7];
      if (v[5:4] == 2'h2) v[5] = 0;
      if (v[13:12] == 3 || (v[13:12] == 1 && v[8])) v[13:12] = 2;
      wr(SPC_OFF_CFG, v);
      apb(SPC_OFF_CFG, 0, 0);
      chk("cfg", rd, v);
      chk("mode", op_mode, v[3:0]);
      chk("clks", clk_src, v[5:4]);
      chk("sck", sck_oe_n, !(v[18] && v[5:4] != SPC_CLK_EXT));
      chk("len", char_bits, v[17] ? 9 : 5 + v[7:6]);
      chk("sync", sync_mode, v[8]);
      chk("par", parity_type, v[11:9]);
      chk("stop", stop_bits, v[13:12]);
      chk("bit_order_select", msb_first, v[16]);
      chk("over", over8, v[19]);
    end
    $display("test config done");
    // Every command bit alone, then an unused bit
    for (int b = 11; b < 21; b++) begin
      wr(SPC_OFF_CMD, 32'h1 << b);
      if (b == 16 || b == 17) md = (b == 17);
      if (b == 18 || b == 19) mr = (b == 19);
      chk("dtr", dtr_n, md);
      chk("rts", rts_n, mr);
    end
    $display("test commands done");
    // Enable and disable in turn, then refused accesses
    for (int i = 0; i < 6; i++) begin
      rnd(v);
      wr(i[0] ? SPC_OFF_IDIS : SPC_OFF_IEN, v);
      m_mask = i[0] ? m_mask & ~v : m_mask | (v & SPC_IRQ_VALID);
      apb(SPC_OFF_IMASK, 0, 0);
      chk("imask", rd, m_mask);
    end
    apb(8'h18, 0, 0);
    chk("unmapped", er, 1);
    apb(SPC_OFF_IMASK, 1, 32'hFFFF_FFFF);
    chk("ro_err", er, 1);
    apb(SPC_OFF_IMASK, 0, 0);
    chk("imask", rd, m_mask);
    $display("test mask done");
    // Modem change flags raise the interrupt, reading clears them
    wr(SPC_OFF_IDIS, 32'hFFFF_FFFF);
    wr(SPC_OFF_IEN, 32'h000F_0000);
    apb(SPC_OFF_STAT, 0, 0);
    for (int k = 0; k < 4; k++) begin
      flip <= 4'h1 << k;
      tick(1);
      flip <= 0;
      for (int n = 0; n < 20 && irq !== 1'b1; n++) tick(1);
      chk("irq", irq, 1);
      apb(SPC_OFF_STAT, 0, 0);
      chk("modem", rd[19:16], 4'h1 << k);
      tick(2);
      chk("irq", irq, 0);
    end
    ext_status[0] <= 1;
    tick(3);
    chk("irq", irq, 0);
    wr(SPC_OFF_IEN, 32'h1);
    tick(2);
    chk("irq", irq, 1);
    $display("test modem done");
    // Smart-card T=0 iteration limit of two
    wr(SPC_OFF_CFG, 32'h0220_0004);
    for (int j = 0; j < 3; j++) begin
      pulse_err;
      chk("nonack_flag", nonack_flag_req, j < 2);
    end
    apb(SPC_OFF_STAT, 0, 0);
    chk("iter", rd[10], 1);
    wr(SPC_OFF_CFG, 0);
    wr(SPC_OFF_CMD, 32'h1 << 13);
    apb(SPC_OFF_STAT, 0, 0);
    chk("iter", rd[10], 1);
    wr(SPC_OFF_CFG, 32'h4);
    wr(SPC_OFF_CMD, 32'h1 << 13);
    apb(SPC_OFF_STAT, 0, 0);
    chk("iter", rd[10], 0);
    nonack_flag_seen <= 1;
    tick(1);
    nonack_flag_seen <= 0;
    apb(SPC_OFF_STAT, 0, 0);
    chk("nackf", rd[13], 1);
    wr(SPC_OFF_CMD, 32'h1 << 14);
    apb(SPC_OFF_STAT, 0, 0);
    chk("nackf", rd[13], 0);
    for (int j = 0; j < 2; j++) begin
      wr(SPC_OFF_CFG, 32'h4 | (j << 20));
      pulse_err;
      chk("nonack_flag", nonack_flag_req, !j);
    end
    $display("test smart card done");
    // Address mark only in multi-drop parity
    for (int p = 0; p < 2; p++) begin
      wr(SPC_OFF_CFG, p ? 32'h0 : 32'hC00);
      wr(SPC_OFF_CMD, 32'h1 << 12);
      for (int j = 0; j < 2; j++) begin
        tx_char_load <= 1;
        tick(1);
        tx_char_load <= 0;
        tick(1);
        chk("addr", tx_addr_bit, p == 0 && j == 0);
      end
    end
    $display("test address done");
    // Channel wiring with receive low and transmitter high
    rx_level <= 0;
    for (int c = 0; c < 4; c++) begin
      wr(SPC_OFF_CFG, c << 14);
      tick(6);
      chk("txd", txd_pin, !c[0]);
      chk("rxl", rx_line, c[1]);
    end
    $display("test channel done");
    // Filter rides out a one-cycle spike, then follows a real level
    wr(SPC_OFF_CFG, 32'h1000_0000);
    tick(12);
    rx_level <= 1;
    tick(1);
    rx_level <= 0;
    for (int k = 0; k < 10; k++) begin
      tick(1);
      chk("filt", rx_line, 0);
    end
    rx_level <= 1;
    tick(12);
    chk("filt", rx_line, 1);
    $display("test filter done");
    end_of_test;
  end
endmodule
